// File: hw/pbmc_pkg.sv
package pbmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PBMC_BMC_OFF   = 8'h00;  // basic_mode_control
  localparam logic [7:0] PBMC_CTL_OFF   = 8'h04;  // fiber mode control
  localparam logic [7:0] PBMC_STAT_OFF  = 8'h08;  // effective operating state

  // ----------------------------------------------------------------
  // Field positions of basic_mode_control
  // ----------------------------------------------------------------
  localparam int PBMC_B_RESET    = 15;
  localparam int PBMC_B_LOOP     = 14;
  localparam int PBMC_B_SPEED    = 13;
  localparam int PBMC_B_ANEG     = 12;
  localparam int PBMC_B_PDOWN    = 11;
  localparam int PBMC_B_ISOLATE  = 10;
  localparam int PBMC_B_DUPLEX   = 8;

  // Field positions of the control register
  localparam int PBMC_C_FIBER    = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] PBMC_BMC_RST     = 16'h0000;
  localparam int          PBMC_CLK_MHZ     = 50;
  localparam int          PBMC_SWRST_NS    = 200;
  localparam int          PBMC_SWRST_CYC   = (PBMC_SWRST_NS * PBMC_CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  PBMC_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  PBMC_RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic [3:0] txd;
    logic       tx_en;
  } pbmc_mii_t;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic aneg_on;
    logic power_down;
    logic isolate;
    logic loopback;
  } pbmc_mode_t;

  typedef enum logic [1:0] {
    PBMC_RUN   = 2'b01,
    PBMC_SWRST = 2'b10
  } pbmc_state_t;

endpackage

// File: hw/pbmc_top.sv
`timescale 1ns/1ps
// What this block does
// - Writing one to reset bit starts reset; reads one until done, then clears.
// - Software reset reloads all strap-derived values like power-on reset.
// - Loopback bit routes MII transmit data back onto MII receive path.
// - With auto-negotiation off, speed bit one gives 100 Mb/s, zero 10 Mb/s.
// - Auto-negotiation enable loads from strap at reset, writable afterwards.
// - Fiber mode enabled forces auto-negotiation enable to zero.
// - Auto-negotiation on makes speed and duplex bits ignored.
// - Auto-negotiation off takes speed and duplex straight from the bits.
// - Power down bit powers down all but the register block.
// - Power down is bit OR active-low pin; pin low also sets the bit.
// - Isolate bit disconnects port from MII; management keeps working.
// - With auto-negotiation off, duplex bit one full, zero half duplex.
module pbmc_top
  import pbmc_pkg::*;
#(
  parameter int SWRST_CYC = PBMC_SWRST_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Straps and pins
  input  wire logic        strap_aneg_in,
  input  wire logic        strap_speed_in,
  input  wire logic        strap_duplex_in,
  input  wire logic        power_down_request_pin_n_in,
  // MII transmit side from the MAC
  input  wire logic        mii_tx_en_in,
  input  wire logic [3:0]  mii_txd_in,
  // Line receive data
  input  wire logic        line_rx_dv_in,
  input  wire logic [3:0]  line_rxd_in,
  // MII receive side to the MAC
  output logic             mii_rx_dv_out,
  output logic [3:0]       mii_rxd_out,
  output logic             mii_rx_oe_n_out,
  // Line transmit and operating mode
  output logic             line_tx_en_out,
  output logic [3:0]       line_txd_out,
  output pbmc_mode_t       mode_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        loop_r, speed_r, aneg_r, pdown_r, iso_r, duplex_r;
  logic        fiber_r;
  logic [2:0]  pd_sync_r;
  logic        pd_pin_r;
  pbmc_state_t state_r;
  logic [15:0] swrst_cnt_r;
  logic        aw_got_r, w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        strap_load;
  logic        wr_go;
  logic        wr_bmc, wr_ctl;
  logic [15:0] bmc_view;
  logic        swrst_busy;

  // ----------------------------------------------------------------
  // Power down pin synchroniser
  // ----------------------------------------------------------------
  // First stage only synchronises; the decision uses stages two and three
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pd_sync_r <= 3'h7;
      pd_pin_r  <= 1'b0;
    end else begin
      pd_sync_r <= {pd_sync_r[1:0], power_down_request_pin_n_in};
      if (pd_sync_r[1] == pd_sync_r[2]) begin
        pd_pin_r <= ~pd_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Software reset sequencer
  // ----------------------------------------------------------------
  assign swrst_busy = (state_r == PBMC_SWRST);
  // Strap values are sampled while reset holds and on the last reset cycle
  assign strap_load = !rst_n_in || (swrst_busy && swrst_cnt_r == 16'h0001);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r     <= PBMC_RUN;
      swrst_cnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        PBMC_RUN: begin
          if (wr_bmc && wstrb_r[1] && wdata_r[PBMC_B_RESET]) begin
            state_r     <= PBMC_SWRST;
            swrst_cnt_r <= 16'(SWRST_CYC);
          end
        end
        PBMC_SWRST: begin
          swrst_cnt_r <= swrst_cnt_r - 16'h0001;
          if (swrst_cnt_r == 16'h0001) begin
            state_r <= PBMC_RUN;
          end
        end
        default: state_r <= PBMC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response once both held
  assign s_axi_awready_out = !aw_got_r && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_got_r && !s_axi_bvalid_out;
  assign wr_go  = aw_got_r && w_got_r && !s_axi_bvalid_out;
  assign wr_bmc = wr_go && awaddr_r == PBMC_BMC_OFF && !swrst_busy;
  assign wr_ctl = wr_go && awaddr_r == PBMC_CTL_OFF;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_got_r         <= 1'b0;
      w_got_r          <= 1'b0;
      awaddr_r         <= 8'h00;
      wdata_r          <= 32'h0000_0000;
      wstrb_r          <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= PBMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_got_r         <= 1'b0;
        w_got_r          <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (awaddr_r == PBMC_BMC_OFF || awaddr_r == PBMC_CTL_OFF ||
                             awaddr_r == PBMC_STAT_OFF) ? PBMC_RESP_OKAY : PBMC_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  // Writes to basic_mode_control during a software reset are dropped, the bank is reinitialising
  always_ff @(posedge clk_in) begin
    if (strap_load) begin
      loop_r   <= 1'b0;
      iso_r    <= 1'b0;
      speed_r  <= strap_speed_in;
      duplex_r <= strap_duplex_in;
      aneg_r   <= strap_aneg_in && !fiber_r;
    end else if (wr_bmc && wstrb_r[1]) begin
      loop_r   <= wdata_r[PBMC_B_LOOP];
      speed_r  <= wdata_r[PBMC_B_SPEED];
      aneg_r   <= wdata_r[PBMC_B_ANEG] && !fiber_r;
      iso_r    <= wdata_r[PBMC_B_ISOLATE];
      duplex_r <= wdata_r[PBMC_B_DUPLEX];
    end else if (fiber_r) begin
      aneg_r <= 1'b0;
    end
  end

  // Pin low wins over a software clear and over the end of a software reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pdown_r <= 1'b0;
    end else if (pd_pin_r) begin
      pdown_r <= 1'b1;
    end else if (strap_load) begin
      pdown_r <= 1'b0;
    end else if (wr_bmc && wstrb_r[1]) begin
      pdown_r <= wdata_r[PBMC_B_PDOWN];
    end
  end

  // Fiber enable survives software reset, it is a board option
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fiber_r <= 1'b0;
    end else if (wr_ctl && wstrb_r[0]) begin
      fiber_r <= wdata_r[PBMC_C_FIBER];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb begin
    bmc_view = 16'h0000;
    bmc_view[PBMC_B_RESET]   = swrst_busy;
    bmc_view[PBMC_B_LOOP]    = loop_r;
    bmc_view[PBMC_B_SPEED]   = speed_r;
    bmc_view[PBMC_B_ANEG]    = aneg_r;
    bmc_view[PBMC_B_PDOWN]   = pdown_r;
    bmc_view[PBMC_B_ISOLATE] = iso_r;
    bmc_view[PBMC_B_DUPLEX]  = duplex_r;
  end

  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= PBMC_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= PBMC_RESP_OKAY;
      unique case ({s_axi_araddr_in[7:2], 2'b00})
        PBMC_BMC_OFF:  s_axi_rdata_out <= {16'h0000, bmc_view};
        PBMC_CTL_OFF:  s_axi_rdata_out <= {31'h0, fiber_r};
        PBMC_STAT_OFF: s_axi_rdata_out <= {26'h0, mode_out};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= PBMC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  // Forced mode bits only count with auto-negotiation off
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_out <= '0;
    end else begin
      mode_out.aneg_on     <= aneg_r;
      mode_out.speed_100   <= aneg_r ? 1'b0 : speed_r;
      mode_out.full_duplex <= aneg_r ? 1'b0 : duplex_r;
      mode_out.power_down  <= pdown_r || pd_pin_r;
      mode_out.isolate     <= iso_r;
      mode_out.loopback    <= loop_r;
    end
  end

  // ----------------------------------------------------------------
  // MII data paths
  // ----------------------------------------------------------------
  // Registered for clean data outputs; power down silences both paths
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mii_rx_dv_out   <= 1'b0;
      mii_rxd_out     <= 4'h0;
      mii_rx_oe_n_out <= 1'b1;
      line_tx_en_out  <= 1'b0;
      line_txd_out    <= 4'h0;
    end else if (iso_r || pdown_r || pd_pin_r) begin
      mii_rx_dv_out   <= 1'b0;
      mii_rxd_out     <= 4'h0;
      mii_rx_oe_n_out <= 1'b1;
      line_tx_en_out  <= 1'b0;
      line_txd_out    <= 4'h0;
    end else if (loop_r) begin
      mii_rx_dv_out   <= mii_tx_en_in;
      mii_rxd_out     <= mii_txd_in;
      mii_rx_oe_n_out <= 1'b0;
      line_tx_en_out  <= 1'b0;
      line_txd_out    <= 4'h0;
    end else begin
      mii_rx_dv_out   <= line_rx_dv_in;
      mii_rxd_out     <= line_rxd_in;
      mii_rx_oe_n_out <= 1'b0;
      line_tx_en_out  <= mii_tx_en_in;
      line_txd_out    <= mii_txd_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_reset_self_clear: assert property (
    $rose(swrst_busy) |-> swrst_busy [*2] ##[1:300] !swrst_busy)
    else $error("software reset bit did not self clear");
  chk_reset_start: assert property (
    (wr_bmc && wstrb_r[1] && wdata_r[PBMC_B_RESET]) |=> bmc_view[PBMC_B_RESET])
    else $error("software reset did not start");
  chk_strap_reload: assert property (
    $fell(swrst_busy) |-> speed_r == $past(strap_speed_in) && duplex_r == $past(strap_duplex_in))
    else $error("straps not reloaded by software reset");
  chk_loop_path: assert property (
    (loop_r && !iso_r && !pdown_r && !pd_pin_r) |=> mii_rxd_out == $past(mii_txd_in))
    else $error("loopback data mismatch");
  chk_fiber_aneg: assert property (
    fiber_r |=> !aneg_r)
    else $error("auto-negotiation enabled in fiber mode");
  chk_forced_mode: assert property (
    !aneg_r |=> mode_out.speed_100 == $past(speed_r) && mode_out.full_duplex == $past(duplex_r))
    else $error("forced speed or duplex not applied");
  chk_aneg_ignores: assert property (
    aneg_r |=> !mode_out.speed_100 && !mode_out.full_duplex)
    else $error("forced bits used under auto-negotiation");
  chk_pin_sets_bit: assert property (
    pd_pin_r |=> pdown_r && mode_out.power_down)
    else $error("power down pin did not set bit");
  chk_isolate_quiet: assert property (
    iso_r |=> !mii_rx_dv_out && mii_rx_oe_n_out && !line_tx_en_out)
    else $error("isolated port drives MII");
  chk_pdown_quiet: assert property (
    (pdown_r || pd_pin_r) |=> mode_out.power_down && mii_rx_oe_n_out && !line_tx_en_out)
    else $error("powered down port drives MII");

  cov_sw_reset: cover property ($fell(swrst_busy));
  cov_loopback: cover property (loop_r && mii_rx_dv_out);
  cov_pin_down: cover property ($rose(pd_pin_r));
  cov_fiber_on: cover property ($rose(fiber_r));
  cov_isolated: cover property (iso_r && mii_rx_oe_n_out);

endmodule

// File: tb/pbmc_mgmt_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Management controller: AXI4-Lite master
// ----------------------------------------
module pbmc_mgmt_model (
  // Clock
  input  wire logic        clk_in,
  // Write channels
  output logic [7:0]       awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic [3:0]       wstrb_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  // Read channels
  output logic [7:0]       araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out
);
  // Idle bus; full words only, so strobes stay on
  initial begin
    awaddr_out = 8'h00;
    awvalid_out = 1'b0;
    wdata_out = 32'h0;
    wstrb_out = 4'hf;
    wvalid_out = 1'b0;
    bready_out = 1'b0;
    araddr_out = 8'h00;
    arvalid_out = 1'b0;
    rready_out = 1'b0;
  end

  // Write: each channel dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
    end while (!bvalid_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask

  // Read: data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready_in) arvalid_out <= 1'b0;
    end while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import pbmc_pkg::*;
  localparam int SW_CYC = 16;  // Reset longer than the 10-cycle default
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, txd, lrxd, rxd, ltxd;
  logic [1:0]  bresp, rresp;
  logic        s_an = 1'b1, s_sp = 1'b1, s_dp = 1'b0, pd_n = 1'b1;
  logic        tx_en = 1'b0, lrx_dv = 1'b0, rx_dv, oe_n, ltx_en;
  logic [15:0] lfsr = 16'h000f;
  pbmc_mode_t  mode;
  int          n_errors = 0;
  int          comparisons = 0;

  always #10 clk_in = ~clk_in;
  initial begin
    txd = 4'h0;
    lrxd = 4'h0;
  end

  pbmc_mgmt_model mgr_u (.clk_in(clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid),
    .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid),
    .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
    .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
    .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

  pbmc_top #(.SWRST_CYC(SW_CYC)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .strap_aneg_in(s_an),
    .strap_speed_in(s_sp), .strap_duplex_in(s_dp), .power_down_request_pin_n_in(pd_n),
    .mii_tx_en_in(tx_en), .mii_txd_in(txd), .line_rx_dv_in(lrx_dv), .line_rxd_in(lrxd),
    .mii_rx_dv_out(rx_dv), .mii_rxd_out(rxd), .mii_rx_oe_n_out(oe_n),
    .line_tx_en_out(ltx_en), .line_txd_out(ltxd), .mode_out(mode));

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic logic [31:0] strap_bmc(input logic a, input logic s, input logic d);
    return {16'h0, 2'b00, s, a, 3'b000, d, 8'h00};
  endfunction

  // Speed and duplex only count with negotiation off
  function automatic pbmc_mode_t exp_mode(input logic [15:0] b);
    logic an;
    an = b[PBMC_B_ANEG];
    return {!an & b[PBMC_B_SPEED], !an & b[PBMC_B_DUPLEX], an, b[PBMC_B_PDOWN],
            b[PBMC_B_ISOLATE], b[PBMC_B_LOOP]};
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] v, w;
    logic        q;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    mgr_u.rd(PBMC_BMC_OFF, d, r);
    `CHK(d, strap_bmc(1'b1, 1'b1, 1'b0))
    $display("test reset values done");
    // Random modes; loopback alone and forced speed/duplex first
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'h4000 : (i == 1) ? 16'h2100 : rnd() & 16'h7d00;
      mgr_u.wr(PBMC_BMC_OFF, {16'h0, v}, r);
      w = rnd();
      tx_en <= w[0];
      txd <= w[4:1];
      lrx_dv <= w[5];
      lrxd <= w[9:6];
      repeat (3) @(posedge clk_in);
      q = v[PBMC_B_ISOLATE] | v[PBMC_B_PDOWN];
      `CHK(mode, exp_mode(v))
      `CHK(oe_n, q)
      `CHK(rx_dv, q ? 1'b0 : (v[PBMC_B_LOOP] ? w[0] : w[5]))
      `CHK(rxd, q ? 4'h0 : (v[PBMC_B_LOOP] ? w[4:1] : w[9:6]))
      `CHK(ltx_en, (q | v[PBMC_B_LOOP]) ? 1'b0 : w[0])
      `CHK(ltxd, (q | v[PBMC_B_LOOP]) ? 4'h0 : w[4:1])
    end
    // Dead time after loopback is the controller's allowance; no data check waits on it
    $display("test modes and traffic done");
    mgr_u.wr(PBMC_BMC_OFF, 32'h0, r);
    pd_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    mgr_u.rd(PBMC_BMC_OFF, d, r);
    `CHK(d[PBMC_B_PDOWN], 1'b1)
    `CHK(mode.power_down, 1'b1)
    mgr_u.wr(PBMC_BMC_OFF, 32'h0, r);
    repeat (2) @(posedge clk_in);
    `CHK(mode.power_down, 1'b1)
    pd_n <= 1'b1;
    repeat (8) @(posedge clk_in);
    mgr_u.wr(PBMC_BMC_OFF, 32'h0, r);
    repeat (2) @(posedge clk_in);
    `CHK(mode.power_down, 1'b0)
    $display("test power down pin done");
    mgr_u.wr(PBMC_CTL_OFF, 32'h1, r);
    mgr_u.wr(PBMC_BMC_OFF, 32'h1000, r);
    mgr_u.rd(PBMC_BMC_OFF, d, r);
    `CHK(d[PBMC_B_ANEG], 1'b0)
    mgr_u.wr(PBMC_CTL_OFF, 32'h0, r);
    $display("test fiber done");
    s_an <= 1'b0;
    s_sp <= 1'b0;
    s_dp <= 1'b1;
    mgr_u.wr(PBMC_BMC_OFF, 32'hc400, r);
    mgr_u.rd(PBMC_BMC_OFF, d, r);
    `CHK(d[PBMC_B_RESET], 1'b1)
    repeat (SW_CYC + 2) @(posedge clk_in);
    mgr_u.rd(PBMC_BMC_OFF, d, r);
    `CHK(d, strap_bmc(1'b0, 1'b0, 1'b1))
    mgr_u.rd(PBMC_STAT_OFF, d, r);
    `CHK(d[5:0], exp_mode(16'h0100))
    $display("test software reset done");
    mgr_u.rd(8'h0c, d, r);
    `CHK({r, d}, {PBMC_RESP_SLVERR, 32'h0})
    mgr_u.wr(8'h0c, 32'hffff, r);
    `CHK(r, PBMC_RESP_SLVERR)
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
